//--- crc16_step.sv
`timescale 1ns/1ps
`include "mb_consts.svh"

module crc16_step (
    input wire logic [15:0] crc_in, // Running CRC
    input wire logic [7:0] data,    // Byte to fold in
    output logic [15:0] crc_out     // CRC after the byte
);

    always_comb begin
        crc_out = crc_in ^ {8'h00, data};
        for (int i = 0; i < `BYTE_BITS; i++) begin
            if (crc_out[0]) begin
                crc_out = (crc_out >> 1) ^ `CRC_POLY;
            end else begin
                crc_out = crc_out >> 1;
            end
        end
    end

endmodule // crc16_step

//--- gap_timer.sv
`timescale 1ns/1ps
`include "mb_consts.svh"

module gap_timer #(
    parameter int unsigned GAP_CYC = `SIL_US * `CLK_MHZ
) (
    input wire logic clk_sys,  // System clock
    input wire logic rst_n,    // Async reset, active low
    input wire logic ce,       // Clock enable
    input wire logic seen,     // Byte taken this cycle
    output logic done          // Pulse: silence after last byte
);

    logic [19:0] cnt_r, cnt_nxt;
    logic run_r, run_nxt;
    logic [19:0] last;

    assign last = 20'(GAP_CYC - 1);
    assign done = run_r && !seen && (cnt_r == last);

    always_comb begin
        cnt_nxt = cnt_r;
        run_nxt = run_r;
        if (seen) begin
            cnt_nxt = 20'h00000;
            run_nxt = 1'b1;
        end else if (done) begin
            run_nxt = 1'b0;
        end else if (run_r) begin
            cnt_nxt = cnt_r + 20'h00001;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 20'h00000;
            run_r <= 1'b0;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
            run_r <= run_nxt;
        end
    end

endmodule // gap_timer

//--- mb_consts.svh
`ifndef MB_CONSTS_SVH
`define MB_CONSTS_SVH

// Function codes and exception encoding
`define FC_LOOP 8'h08
`define FC_COILS 8'h0f
`define FC_REGS 8'h10
`define EXC_FLAG 8'h80
`define EXC_NONE 8'h00
`define EXC_FUNC 8'h01
`define EXC_ADDR 8'h02
`define EXC_DATA 8'h03
`define ADDR_BCAST 8'h00
`define SUB_ECHO 16'h0000

// Byte positions inside a query frame
`define IX_ADDR 6'h00
`define IX_FC 6'h01
`define IX_P1H 6'h02
`define IX_P1L 6'h03
`define IX_P2H 6'h04
`define IX_P2L 6'h05
`define IX_BC 6'h06
`define IX_DATA 6'h07

// Frame lengths
`define RX_DEPTH 7'h40
`define MIN_LEN 7'h04
`define LOOP_LEN 7'h08
`define WR_OVH 9'h009
`define BODY_ACK 4'h6
`define BODY_EXC 4'h3
`define FIRST_OFS 16'h0001

// Coil byte packing
`define BITS_RND 17'h00007
`define BITS_SHIFT 3

// Address space limits
`define COIL_LAST 16'h00ff
`define REG_LAST 16'hffff

// CRC-16
`define CRC_INIT 16'hffff
`define CRC_POLY 16'ha001
`define BYTE_BITS 8

// Inter-frame silence
`define SIL_US 1750
`define CLK_MHZ 250

`endif

//--- mb_master.sv
`timescale 1ns/1ps
// ==========================================
// Bus master stand-in: sends queries, sinks replies
module mb_master (
    input wire logic clk_sys,       // System clock
    input wire logic rst_n,         // Async reset, active low
    input wire logic stall,         // Take reply bytes at random
    output logic rx_valid,          // Query byte strobe
    output logic [7:0] rx_byte,     // Query byte
    input wire logic tx_valid,      // Reply byte offered
    output logic tx_ready,          // Reply byte taken
    input wire logic [7:0] tx_byte  // Reply byte
);
    mb_pkg::byte_t frame[$];
    mb_pkg::byte_t rsp[$];
    int seed = 42297;

    initial begin
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        tx_ready = 1'b0;
    end

    function automatic logic [15:0] crc16(input mb_pkg::byte_t q[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int b = 0; b < 8; b++) begin
                c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
            end
        end
        return c;
    endfunction

    // Caller enters just after a rising edge
    task automatic send_frame();
        logic [15:0] c;
        int k;
        c = crc16(frame);
        frame.push_back(c[15:8]);
        frame.push_back(c[7:0]);
        foreach (frame[i]) begin
            rx_valid = 1'b1;
            rx_byte = frame[i];
            @(posedge clk_sys);
            #1;
            k = $unsigned($random(seed)) % 3;
            // Back to back bytes keep the strobe up; a gap or the frame end drops it
            if (k > 0 || i == frame.size() - 1) begin
                rx_valid = 1'b0;
                // Released data line shows the inverse, not a stale copy
                rx_byte = ~frame[i];
            end
            repeat (k) begin
                @(posedge clk_sys);
                #1;
            end
        end
    endtask

    always @(posedge clk_sys) begin
        if (rst_n && tx_valid && tx_ready) begin
            rsp.push_back(tx_byte);
        end
        #1;
        tx_ready = stall ? 1'($random(seed)) : 1'b1;
    end
endmodule // mb_master

//--- mb_pkg.sv
package mb_pkg;

    typedef enum logic [1:0] {
        ST_RECV = 2'b00,
        ST_CHECK = 2'b01,
        ST_WRITE = 2'b10,
        ST_SEND = 2'b11
    } st_e;

    typedef logic [7:0] byte_t;

endpackage

//--- mb_slave.sv
`timescale 1ns/1ps
`include "mb_consts.svh"

// Notes on behaviour
// - Loopback reply echoes every query field
// - Only subcode zero is accepted
// - Loopback frame is eight bytes
// - Coil write updates consecutive coils
// - Coil acknowledge is eight bytes, no data
// - First coil is start field plus one
// - Broadcast writes get no reply
// - Failed non-broadcast writes get an exception reply
// - Register write stores consecutive 16-bit words
// - Register acknowledge is eight bytes
// - First register is start field plus one
// - 32-bit values span two registers, upper first
// - Fields upper byte first, CRC-16 last
// - Exception: address, function plus 80h, code
// - Codes 01h, 02h, 03h for errors
module mb_slave #(
    parameter int unsigned GAP_CYC = `SIL_US * `CLK_MHZ
) (
    input wire logic clk_sys,          // System clock
    input wire logic rst_n,            // Async reset, active low
    input wire logic ce,               // Clock enable
    input wire logic [7:0] slave_addr, // Own station address
    input wire logic rx_valid,         // Received byte strobe
    input wire logic [7:0] rx_byte,    // Received byte
    output logic tx_valid,             // Response byte offered
    input wire logic tx_ready,         // Response byte taken
    output logic [7:0] tx_byte,        // Response byte
    output logic coil_we,              // Coil write strobe
    output logic [15:0] coil_addr,     // Coil number
    output logic coil_val,             // Coil value
    output logic reg_we,               // Register write strobe
    output logic [15:0] reg_addr,      // Register address
    output logic [15:0] reg_wdata      // Register word
);

    // ==========================================================
    // State
    // ==========================================================
    mb_pkg::st_e st_r, st_nxt;
    mb_pkg::byte_t rx_buf_r [64];
    mb_pkg::byte_t rx_buf_nxt [64];
    logic [6:0] len_r, len_nxt;
    logic ovf_r, ovf_nxt;
    logic [7:0] tail1_r, tail1_nxt, tail0_r, tail0_nxt;
    logic [15:0] crc_r, crc_nxt, crc_d1_r, crc_d1_nxt, crc_d2_r, crc_d2_nxt;
    logic exc_r, exc_nxt;
    logic [7:0] code_r, code_nxt;
    logic quiet_r, quiet_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [3:0] idx_r, idx_nxt;
    logic [15:0] txcrc_r, txcrc_nxt;
    logic [7:0] tx_byte_r, tx_byte_nxt;
    logic coil_we_r, coil_we_nxt, coil_val_r, coil_val_nxt;
    logic [15:0] coil_addr_r, coil_addr_nxt;
    logic reg_we_r, reg_we_nxt;
    logic [15:0] reg_addr_r, reg_addr_nxt, reg_wdata_r, reg_wdata_nxt;

    // ==========================================================
    // Decoded fields
    // ==========================================================
    logic rx_acc, gap_done, tx_fire;
    logic [7:0] fc;
    logic [15:0] p1, p2, rx_crc_out, tx_crc_out;
    logic [3:0] body;
    logic [5:0] coil_ix, reg_ix;

    assign fc = rx_buf_r[`IX_FC];
    assign p1 = {rx_buf_r[`IX_P1H], rx_buf_r[`IX_P1L]};
    assign p2 = {rx_buf_r[`IX_P2H], rx_buf_r[`IX_P2L]};
    assign body = exc_r ? `BODY_EXC : `BODY_ACK;
    assign rx_acc = rx_valid && (st_r == mb_pkg::ST_RECV);
    assign tx_valid = (st_r == mb_pkg::ST_SEND);
    assign tx_fire = tx_valid && tx_ready;
    assign coil_ix = `IX_DATA + cnt_r[8:3];
    assign reg_ix = `IX_DATA + {cnt_r[4:0], 1'b0};

    assign tx_byte = tx_byte_r;
    assign coil_we = coil_we_r;
    assign coil_addr = coil_addr_r;
    assign coil_val = coil_val_r;
    assign reg_we = reg_we_r;
    assign reg_addr = reg_addr_r;
    assign reg_wdata = reg_wdata_r;

    crc16_step u_rx_crc (
        .crc_in(crc_r),
        .data(rx_byte),
        .crc_out(rx_crc_out)
    );

    crc16_step u_tx_crc (
        .crc_in(txcrc_r),
        .data(tx_byte_r),
        .crc_out(tx_crc_out)
    );

    gap_timer #(
        .GAP_CYC(GAP_CYC)
    ) u_gap (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .seen(rx_acc),
        .done(gap_done)
    );

    // Response body: echo of query head, or exception triple
    function automatic logic [7:0] body_byte(input logic [3:0] i);
        if (!exc_r) begin
            body_byte = rx_buf_r[6'(i)];
        end else if (i == 4'h0) begin
            body_byte = rx_buf_r[`IX_ADDR];
        end else if (i == 4'h1) begin
            body_byte = fc | `EXC_FLAG;
        end else begin
            body_byte = code_r;
        end
    endfunction

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        logic [7:0] code;
        logic bcast, mine, crc_ok, len_ok, rng_bad;
        logic [16:0] nb, need, p1_end;
        code = `EXC_NONE;
        bcast = (rx_buf_r[`IX_ADDR] == `ADDR_BCAST);
        mine = (rx_buf_r[`IX_ADDR] == slave_addr);
        crc_ok = (len_r >= `MIN_LEN) && ({tail1_r, tail0_r} == crc_d2_r);
        len_ok = ({2'b00, len_r} == ({1'b0, rx_buf_r[`IX_BC]} + `WR_OVH));
        p1_end = {1'b0, p1} + {1'b0, p2};
        nb = ({1'b0, p2} + `BITS_RND) >> `BITS_SHIFT;
        need = nb + {16'h0000, nb[0]};
        rng_bad = 1'b0;
        st_nxt = st_r;
        rx_buf_nxt = rx_buf_r;
        len_nxt = len_r;
        ovf_nxt = ovf_r;
        tail1_nxt = tail1_r;
        tail0_nxt = tail0_r;
        crc_nxt = crc_r;
        crc_d1_nxt = crc_d1_r;
        crc_d2_nxt = crc_d2_r;
        exc_nxt = exc_r;
        code_nxt = code_r;
        quiet_nxt = quiet_r;
        cnt_nxt = cnt_r;
        idx_nxt = idx_r;
        txcrc_nxt = txcrc_r;
        tx_byte_nxt = tx_byte_r;
        coil_we_nxt = 1'b0;
        coil_addr_nxt = coil_addr_r;
        coil_val_nxt = coil_val_r;
        reg_we_nxt = 1'b0;
        reg_addr_nxt = reg_addr_r;
        reg_wdata_nxt = reg_wdata_r;
        unique case (st_r)
            mb_pkg::ST_RECV: begin
                if (rx_acc) begin
                    if (len_r < `RX_DEPTH) begin
                        rx_buf_nxt[len_r[5:0]] = rx_byte;
                        len_nxt = len_r + 7'h01;
                    end else begin
                        ovf_nxt = 1'b1;
                    end
                    tail1_nxt = tail0_r;
                    tail0_nxt = rx_byte;
                    crc_nxt = rx_crc_out;
                    crc_d1_nxt = crc_r;
                    crc_d2_nxt = crc_d1_r;
                end else if (gap_done) begin
                    st_nxt = mb_pkg::ST_CHECK;
                end
            end
            mb_pkg::ST_CHECK: begin
                len_nxt = 7'h00;
                ovf_nxt = 1'b0;
                crc_nxt = `CRC_INIT;
                crc_d1_nxt = `CRC_INIT;
                crc_d2_nxt = `CRC_INIT;
                cnt_nxt = 16'h0000;
                idx_nxt = 4'h0;
                txcrc_nxt = `CRC_INIT;
                tx_byte_nxt = rx_buf_r[`IX_ADDR];
                quiet_nxt = bcast;
                if (ovf_r) begin
                    code = `EXC_DATA;
                end else begin
                    unique case (fc)
                        `FC_LOOP: begin
                            if (len_r != `LOOP_LEN) begin
                                code = `EXC_DATA;
                            end else if (p1 != `SUB_ECHO) begin
                                code = `EXC_FUNC;
                            end
                        end
                        `FC_COILS: begin
                            rng_bad = p1_end > {1'b0, `COIL_LAST};
                            if (!len_ok || p2 == 16'h0000 || {9'h000, rx_buf_r[`IX_BC]} != need) begin
                                code = `EXC_DATA;
                            end else if (rng_bad) begin
                                code = `EXC_ADDR;
                            end
                        end
                        `FC_REGS: begin
                            rng_bad = p1_end > {1'b0, `REG_LAST};
                            if (!len_ok || p2 == 16'h0000 || {9'h000, rx_buf_r[`IX_BC]} != {p2, 1'b0}) begin
                                code = `EXC_DATA;
                            end else if (rng_bad) begin
                                code = `EXC_ADDR;
                            end
                        end
                        default: begin
                            code = `EXC_FUNC;
                        end
                    endcase
                end
                code_nxt = code;
                exc_nxt = (code != `EXC_NONE);
                if (!crc_ok || !(mine || bcast)) begin
                    st_nxt = mb_pkg::ST_RECV;
                end else if (code != `EXC_NONE) begin
                    st_nxt = bcast ? mb_pkg::ST_RECV : mb_pkg::ST_SEND;
                end else if (fc == `FC_LOOP) begin
                    st_nxt = bcast ? mb_pkg::ST_RECV : mb_pkg::ST_SEND;
                end else begin
                    st_nxt = mb_pkg::ST_WRITE;
                end
            end
            mb_pkg::ST_WRITE: begin
                cnt_nxt = cnt_r + 16'h0001;
                if (fc == `FC_COILS) begin
                    coil_we_nxt = 1'b1;
                    coil_addr_nxt = p1 + `FIRST_OFS + cnt_r;
                    coil_val_nxt = rx_buf_r[coil_ix][cnt_r[2:0]];
                end else begin
                    reg_we_nxt = 1'b1;
                    reg_addr_nxt = p1 + `FIRST_OFS + cnt_r;
                    reg_wdata_nxt = {rx_buf_r[reg_ix], rx_buf_r[reg_ix + 6'h01]};
                end
                if (cnt_r == p2 - 16'h0001) begin
                    st_nxt = quiet_r ? mb_pkg::ST_RECV : mb_pkg::ST_SEND;
                end
            end
            mb_pkg::ST_SEND: begin
                if (tx_fire) begin
                    if (idx_r == body + 4'h1) begin
                        st_nxt = mb_pkg::ST_RECV;
                    end else begin
                        idx_nxt = idx_r + 4'h1;
                        if (idx_r < body) begin
                            txcrc_nxt = tx_crc_out;
                        end
                        if (idx_r + 4'h1 < body) begin
                            tx_byte_nxt = body_byte(idx_r + 4'h1);
                        end else if (idx_r + 4'h1 == body) begin
                            tx_byte_nxt = tx_crc_out[15:8];
                        end else begin
                            tx_byte_nxt = txcrc_r[7:0];
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= mb_pkg::ST_RECV;
            for (int i = 0; i < 64; i++) begin
                rx_buf_r[i] <= 8'h00;
            end
            len_r <= 7'h00;
            ovf_r <= 1'b0;
            tail1_r <= 8'h00;
            tail0_r <= 8'h00;
            crc_r <= `CRC_INIT;
            crc_d1_r <= `CRC_INIT;
            crc_d2_r <= `CRC_INIT;
            exc_r <= 1'b0;
            code_r <= `EXC_NONE;
            quiet_r <= 1'b0;
            cnt_r <= 16'h0000;
            idx_r <= 4'h0;
            txcrc_r <= `CRC_INIT;
            tx_byte_r <= 8'h00;
            coil_we_r <= 1'b0;
            coil_addr_r <= 16'h0000;
            coil_val_r <= 1'b0;
            reg_we_r <= 1'b0;
            reg_addr_r <= 16'h0000;
            reg_wdata_r <= 16'h0000;
        end else if (ce) begin
            st_r <= st_nxt;
            rx_buf_r <= rx_buf_nxt;
            len_r <= len_nxt;
            ovf_r <= ovf_nxt;
            tail1_r <= tail1_nxt;
            tail0_r <= tail0_nxt;
            crc_r <= crc_nxt;
            crc_d1_r <= crc_d1_nxt;
            crc_d2_r <= crc_d2_nxt;
            exc_r <= exc_nxt;
            code_r <= code_nxt;
            quiet_r <= quiet_nxt;
            cnt_r <= cnt_nxt;
            idx_r <= idx_nxt;
            txcrc_r <= txcrc_nxt;
            tx_byte_r <= tx_byte_nxt;
            coil_we_r <= coil_we_nxt;
            coil_addr_r <= coil_addr_nxt;
            coil_val_r <= coil_val_nxt;
            reg_we_r <= reg_we_nxt;
            reg_addr_r <= reg_addr_nxt;
            reg_wdata_r <= reg_wdata_nxt;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    sequence s_ack_last;
        ce && tx_fire && !exc_r && idx_r == 4'h7;
    endsequence

    property p_ack_eight;
        @(posedge clk_sys) disable iff (!rst_n) s_ack_last |=> st_r == mb_pkg::ST_RECV;
    endproperty
    a_ack_eight: assert property (p_ack_eight) else $error("ack not eight bytes");

    property p_bcast_silent;
        @(posedge clk_sys) disable iff (!rst_n) tx_valid |-> rx_buf_r[`IX_ADDR] != `ADDR_BCAST;
    endproperty
    a_bcast_silent: assert property (p_bcast_silent) else $error("reply to broadcast");

    property p_foreign;
        @(posedge clk_sys) disable iff (!rst_n)
            ce && st_r == mb_pkg::ST_CHECK && rx_buf_r[`IX_ADDR] != slave_addr
            && rx_buf_r[`IX_ADDR] != `ADDR_BCAST |=> st_r == mb_pkg::ST_RECV;
    endproperty
    a_foreign: assert property (p_foreign) else $error("foreign query served");

    property p_exc_fc;
        @(posedge clk_sys) disable iff (!rst_n)
            tx_valid && exc_r && idx_r == 4'h1 |-> tx_byte == (fc | `EXC_FLAG);
    endproperty
    a_exc_fc: assert property (p_exc_fc) else $error("bad exception function");

    property p_exc_code;
        @(posedge clk_sys) disable iff (!rst_n)
            tx_valid && exc_r |-> code_r inside {`EXC_FUNC, `EXC_ADDR, `EXC_DATA};
    endproperty
    a_exc_code: assert property (p_exc_code) else $error("bad exception code");

    property p_echo;
        @(posedge clk_sys) disable iff (!rst_n)
            tx_valid && !exc_r && idx_r < `BODY_ACK |-> tx_byte == rx_buf_r[6'(idx_r)];
    endproperty
    a_echo: assert property (p_echo) else $error("echo byte wrong");

    property p_subcode;
        @(posedge clk_sys) disable iff (!rst_n)
            ce && st_r == mb_pkg::ST_CHECK && !ovf_r && fc == `FC_LOOP && len_r == `LOOP_LEN
            && p1 != `SUB_ECHO |=> exc_r && code_r == `EXC_FUNC;
    endproperty
    a_subcode: assert property (p_subcode) else $error("subcode accepted");

    property p_coil_first;
        @(posedge clk_sys) disable iff (!rst_n)
            $rose(coil_we) |-> coil_addr == p1 + `FIRST_OFS && coil_val == rx_buf_r[`IX_DATA][0];
    endproperty
    a_coil_first: assert property (p_coil_first) else $error("first coil wrong");

    property p_reg_first;
        @(posedge clk_sys) disable iff (!rst_n)
            $rose(reg_we) |-> reg_addr == p1 + `FIRST_OFS
            && reg_wdata == {rx_buf_r[`IX_DATA], rx_buf_r[`IX_DATA + 6'h01]};
    endproperty
    a_reg_first: assert property (p_reg_first) else $error("first register wrong");

    property p_crc_hi;
        @(posedge clk_sys) disable iff (!rst_n)
            tx_valid && idx_r == body |-> tx_byte == txcrc_r[15:8];
    endproperty
    a_crc_hi: assert property (p_crc_hi) else $error("crc upper byte wrong");

endmodule // mb_slave

//--- modbus_slave_diag_multiwrite_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
// ==========================================
// Top: slave under test against the master model
module modbus_slave_diag_multiwrite_tb;
    logic clk_sys, rst_n, ce, stall, rx_valid, tx_valid, tx_ready;
    logic coil_we, coil_val, reg_we;
    logic [7:0] slave_addr, rx_byte, tx_byte;
    logic [15:0] coil_addr, reg_addr, reg_wdata;
    mb_pkg::byte_t qry[$], exp_rsp[$];
    logic [16:0] exp_cw[$], got_cw[$];
    logic [31:0] exp_rw[$], got_rw[$];
    int n_mismatch = 0;
    int cmp_count = 0;
    int seed = 42297;
    int unsigned r;

    mb_slave #(.GAP_CYC(20)) mb_slave_i (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .slave_addr(slave_addr),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte),
        .coil_we(coil_we), .coil_addr(coil_addr), .coil_val(coil_val), .reg_we(reg_we), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata));
    mb_master mb_master_i (.clk_sys(clk_sys), .rst_n(rst_n), .stall(stall), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (coil_we === 1'b1) got_cw.push_back({coil_addr, coil_val});
        if (reg_we === 1'b1) got_rw.push_back({reg_addr, reg_wdata});
    end

    // ==========================================
    // Frame builders and expectations
    task automatic start(input logic [7:0] a, input logic [7:0] fc);
        qry.delete();
        exp_rsp.delete();
        exp_cw.delete();
        exp_rw.delete();
        qry.push_back(a);
        qry.push_back(fc);
    endtask

    task automatic put16(input logic [15:0] v);
        qry.push_back(v[15:8]);
        qry.push_back(v[7:0]);
    endtask

    task automatic add_crc();
        logic [15:0] c;
        c = mb_master_i.crc16(exp_rsp);
        exp_rsp.push_back(c[15:8]);
        exp_rsp.push_back(c[7:0]);
    endtask

    // Echo of the first six query bytes, silent on broadcast
    task automatic ack();
        if (qry[0] != 8'h00) begin
            for (int i = 0; i < 6; i++) exp_rsp.push_back(qry[i]);
            add_crc();
        end
    endtask

    task automatic exc(input logic [7:0] code);
        exp_cw.delete();
        exp_rw.delete();
        exp_rsp.delete();
        if (qry[0] != 8'h00) begin
            exp_rsp.push_back(qry[0]);
            exp_rsp.push_back(qry[1] | 8'h80);
            exp_rsp.push_back(code);
            add_crc();
        end
    endtask

    task automatic mk_coil(input logic [7:0] a, input logic [15:0] st, input logic [15:0] n, input logic [7:0] d0);
        int bc;
        logic [7:0] d;
        start(a, 8'h0f);
        put16(st);
        put16(n);
        bc = ((int'(n) + 7) / 8 + 1) & ~1;
        qry.push_back(8'(bc));
        for (int i = 0; i < bc; i++) begin
            d = (i == 0) ? d0 : 8'($random(seed));
            qry.push_back(d);
            for (int b = 0; b < 8; b++) begin
                if (i * 8 + b < int'(n)) exp_cw.push_back({st + 16'(1 + i * 8 + b), d[b]});
            end
        end
        ack();
    endtask

    task automatic mk_regs(input logic [7:0] a, input logic [15:0] st, input logic [15:0] n,
        input logic [15:0] w0, input logic [15:0] w1);
        logic [15:0] w;
        start(a, 8'h10);
        put16(st);
        put16(n);
        qry.push_back(8'(2 * n));
        for (int i = 0; i < int'(n); i++) begin
            w = (i == 0) ? w0 : (i == 1) ? w1 : 16'($random(seed));
            put16(w);
            exp_rw.push_back({st + 16'(1 + i), w});
        end
        ack();
    endtask

    task automatic mk_loop(input logic [7:0] a, input logic [15:0] sub, input logic [15:0] d);
        start(a, 8'h08);
        put16(sub);
        put16(d);
        if (sub == 16'h0000) begin
            ack();
        end else begin
            exc(8'h01);
        end
    endtask

    // ==========================================
    // One frame out, reply and strokes compared
    task automatic run(input string name);
        @(posedge clk_sys);
        #1;
        got_cw.delete();
        got_rw.delete();
        mb_master_i.rsp.delete();
        mb_master_i.frame = qry;
        mb_master_i.send_frame();
        // Freeze the block past the silence span: nothing may move until enable returns
        ce = 1'b0;
        repeat (30) @(posedge clk_sys);
        #1;
        `CHK(tx_valid, 1'b0)
        ce = 1'b1;
        for (int k = 0; k < 400 && mb_master_i.rsp.size() < exp_rsp.size(); k++) @(posedge clk_sys);
        repeat (60) @(posedge clk_sys);
        #1;
        `CHK(mb_master_i.rsp.size(), exp_rsp.size())
        foreach (exp_rsp[i]) if (i < mb_master_i.rsp.size()) `CHK(mb_master_i.rsp[i], exp_rsp[i])
        `CHK(got_cw.size(), exp_cw.size())
        foreach (exp_cw[i]) if (i < got_cw.size()) `CHK(got_cw[i], exp_cw[i])
        `CHK(got_rw.size(), exp_rw.size())
        foreach (exp_rw[i]) if (i < got_rw.size()) `CHK(got_rw[i], exp_rw[i])
        `CHK(tx_valid, 1'b0)
        $display("test %s done", name);
    endtask

    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #(4 * 30000);
        n_mismatch++;
        final_report();
    end

    initial begin
        ce = 1'b1;
        stall = 1'b0;
        slave_addr = 8'h05;
        rst_n = 1'b0;
        repeat (16) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        `CHK(tx_valid, 1'b0)
        `CHK(coil_we, 1'b0)
        `CHK(reg_we, 1'b0)
        mk_coil(8'h05, 16'h0006, 16'h0006, 8'h17);
        run("coil_example");
        slave_addr = 8'h01;
        mk_regs(8'h01, 16'h1102, 16'h0002, 16'h0004, 16'h93e0);
        run("reg_example");
        mk_loop(8'h01, 16'h0000, 16'h1234);
        run("loop_echo");
        mk_loop(8'h01, 16'h0001, 16'h5678);
        run("loop_bad_sub");
        start(8'h01, 8'h08);
        put16(16'h0000);
        exc(8'h03);
        run("loop_short");
        mk_regs(8'h01, 16'hffff, 16'h0002, 16'h1111, 16'h2222);
        exc(8'h02);
        run("reg_range");
        mk_coil(8'h01, 16'h0000, 16'h0000, 8'h00);
        exc(8'h03);
        run("coil_zero");
        start(8'h01, 8'h03);
        put16(16'h0000);
        put16(16'h0001);
        exc(8'h01);
        run("bad_func");
        mk_regs(8'h01, 16'h0010, 16'h0002, 16'h1111, 16'h2222);
        qry[6] = 8'h02;
        exc(8'h03);
        run("reg_bad_count");
        mk_coil(8'h01, 16'h00f8, 16'h0010, 8'h00);
        exc(8'h02);
        run("coil_range");
        mk_coil(8'h01, 16'h00ef, 16'h0010, 8'ha5);
        run("coil_top");
        mk_coil(8'h00, 16'h0020, 16'h0009, 8'h3c);
        run("coil_bcast");
        mk_regs(8'h00, 16'h0200, 16'h0003, 16'h0001, 16'h0002);
        run("reg_bcast");
        mk_regs(8'h02, 16'h0300, 16'h0001, 16'habcd, 16'h0000);
        exp_rsp.delete();
        exp_rw.delete();
        run("foreign");
        stall = 1'b1;
        repeat (24) begin
            r = $unsigned($random(seed));
            case (r % 3)
                0: mk_loop(8'h01, 16'h0000, 16'(r >> 8));
                1: mk_coil(8'h01, 16'((r >> 8) % 224), 16'(1 + (r >> 16) % 16), 8'(r >> 4));
                default: mk_regs(8'h01, 16'(r >> 4) & 16'h7fff, 16'(1 + (r >> 20) % 4), 16'(r), 16'(r >> 12));
            endcase
            run("random");
        end
        final_report();
    end
endmodule // modbus_slave_diag_multiwrite_tb
